//--- shared/rstirq_params.svh
`ifndef RSTIRQ_PARAMS_SVH
`define RSTIRQ_PARAMS_SVH

`define RSTIRQ_VEC_RESET 16'h0FFE
`define RSTIRQ_VEC_SWI 16'h0FFC
`define RSTIRQ_VEC_EXT 16'h0FFA
`define RSTIRQ_VEC_CT 16'h0FF8
`define RSTIRQ_VEC_PT 16'h0FF6

`define RSTIRQ_RAM_LO 16'h0080
`define RSTIRQ_RAM_HI 16'h00FF
`define RSTIRQ_EE_LO 16'h0100
`define RSTIRQ_EE_HI 16'h017F
`define RSTIRQ_PROG_LO 16'h0300
`define RSTIRQ_PROG_HI 16'h0EFF
`define RSTIRQ_VTAB_LO 16'h0FF6
`define RSTIRQ_VTAB_HI 16'h0FFF

`define RSTIRQ_REG_CTRL 6'h00
`define RSTIRQ_REG_STAT 6'h01
`define RSTIRQ_REG_COUNT 6'h02
`define RSTIRQ_REG_WDOG 6'h03

`define RSTIRQ_CTL_EXT_LEVEL 0
`define RSTIRQ_CTL_WDOG_OPT 1
`define RSTIRQ_CTL_RT_IE 2
`define RSTIRQ_CTL_WRAP_IE 3
`define RSTIRQ_CTL_KBD_IE 4
`define RSTIRQ_CTL_RESET 16'h0F00

`define RSTIRQ_ST_RTF 0
`define RSTIRQ_ST_CTF 1
`define RSTIRQ_ST_KSF 2
`define RSTIRQ_ST_EXT 3
`define RSTIRQ_CAUSE_POR 0
`define RSTIRQ_CAUSE_PIN 1
`define RSTIRQ_CAUSE_ILL 2
`define RSTIRQ_CAUSE_WDOG 3

`define RSTIRQ_CLK_NS 5
`define RSTIRQ_TCYC_NS 5
`define RSTIRQ_RST_PIN_MIN_TCYC_X10 15
`define RSTIRQ_RST_PIN_MIN_CYC \
  ((`RSTIRQ_RST_PIN_MIN_TCYC_X10 * `RSTIRQ_TCYC_NS + 10 * `RSTIRQ_CLK_NS - 1) / (10 * `RSTIRQ_CLK_NS))
`define RSTIRQ_POR_DELAY_CYCLES 4064
`define RSTIRQ_WDOG_CYCLES 262144
`define RSTIRQ_POR_CNT_W 16
`define RSTIRQ_WDOG_CNT_W 20
`define RSTIRQ_STACK_FRAME 3'h5
`define RSTIRQ_SP_RESET 6'h3F

`endif

//--- shared/rstirq_pkg.sv
`include "rstirq_params.svh"

package rstirq_pkg;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN,
    ST_STACK,
    ST_UNSTACK
  } rstirq_state_e;

  typedef struct packed {
    rstirq_state_e st;
    logic [1:0] rpin_s;
    logic [1:0] irq_s;
    logic [1:0] mode_s;
    logic [5:0] kb_s1;
    logic [5:0] kb_s2;
    logic irq_prev;
    logic kb_prev;
    logic [1:0] rpin_cnt;
    logic [`RSTIRQ_POR_CNT_W-1:0] por_cnt;
    logic por_done;
    logic [`RSTIRQ_WDOG_CNT_W-1:0] wdog_cnt;
    logic [15:0] ctl;
    logic rtf;
    logic ctf;
    logic keypad_status_flag;
    logic ext_latch;
    logic [3:0] cause;
    logic [7:0] ct_cnt;
    logic [7:0] rt_cnt;
    logic mask;
    logic [5:0] sp;
    logic [2:0] fcnt;
    logic [15:0] vec;
    logic [15:0] vec_lo;
    logic vec_load;
    logic push;
    logic pop;
    logic [7:0] stk_addr;
    logic sys_reset;
    logic wake;
    logic op_mode;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rstirq_regs_s;

endpackage : rstirq_pkg

//--- tb/rstirq_cpu_model.sv
`timescale 1ns/1ps
module rstirq_cpu_model (
  input wire logic mclk,
  input wire logic vector_load,
  input wire logic [15:0] vector_hi_addr,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [7:0] stack_addr,
  output logic cpu_fetch,
  output logic [15:0] cpu_addr,
  output logic cpu_instr_done,
  output logic cpu_swi,
  output logic cpu_rti,
  output logic cpu_stacked_mask,
  output logic cpu_mask_set,
  output logic cpu_mask_clr
);
  initial begin
    cpu_fetch = 1'b0;
    cpu_addr = 16'h0300;
    cpu_instr_done = 1'b0;
    cpu_swi = 1'b0;
    cpu_rti = 1'b0;
    cpu_stacked_mask = 1'b1;
    cpu_mask_set = 1'b0;
    cpu_mask_clr = 1'b0;
  end

  // Pushes only count while addresses step down from the first one
  task automatic boundary(input logic software_trap_instr, output logic [15:0] vec, output int n,
                          output logic [7:0] a0);
    int i;
    vec = 16'h0000;
    n = 0;
    a0 = 8'h00;
    @(posedge mclk);
    cpu_instr_done <= 1'b1;
    cpu_swi <= software_trap_instr;
    @(posedge mclk);
    cpu_instr_done <= 1'b0;
    cpu_swi <= 1'b0;
    for (i = 0; i < 10; i++) begin
      #1;
      if (stack_push === 1'b1 && n == 0) a0 = stack_addr;
      if (stack_push === 1'b1 && stack_addr === a0 - 8'(n)) n++;
      if (vector_load === 1'b1) vec = vector_hi_addr;
      @(posedge mclk);
    end
  endtask : boundary

  // Stacked mask held through the whole unstack, sampled late by the block
  task automatic return_from_trap_instr(input logic m, output int n);
    int i;
    n = 0;
    @(posedge mclk);
    cpu_rti <= 1'b1;
    cpu_stacked_mask <= m;
    @(posedge mclk);
    cpu_rti <= 1'b0;
    for (i = 0; i < 10; i++) begin
      #1;
      if (stack_pop === 1'b1) n++;
      @(posedge mclk);
    end
  endtask : return_from_trap_instr

  task automatic mask_op(input logic s);
    @(posedge mclk);
    cpu_mask_set <= s;
    cpu_mask_clr <= !s;
    @(posedge mclk);
    cpu_mask_set <= 1'b0;
    cpu_mask_clr <= 1'b0;
  endtask : mask_op

  task automatic fetch(input logic [15:0] a);
    @(posedge mclk);
    cpu_fetch <= 1'b1;
    cpu_addr <= a;
    @(posedge mclk);
    cpu_fetch <= 1'b0;
  endtask : fetch
endmodule : rstirq_cpu_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sys_reset, vector_load, stack_push, stack_pop, mask_bit, wake, op_mode;
  logic rst_pin_n = 1'b0, irq_pin_n = 1'b1, mode_pin = 1'b1, prog_timer_req = 1'b0;
  logic cpu_fetch, cpu_instr_done, cpu_swi, cpu_rti, cpu_stacked_mask, cpu_mask_set;
  logic cpu_mask_clr;
  logic [5:0] kbd_pins_n = 6'h3F;
  logic cpu_stop = 1'b0, cpu_wait = 1'b0;
  logic [15:0] cpu_addr, vector_hi_addr, vector_lo_addr;
  logic [7:0] stack_addr;
  int error_cnt = 0, cmp_count = 0, cyc = 0;

  always #2.5 mclk = ~mclk;

  rstirq_ctrl #(.POR_CYCLES(8), .WDOG_CYCLES(64)) dut (.mclk(mclk), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n),
    .irq_pin_n(irq_pin_n), .kbd_pins_n(kbd_pins_n), .mode_pin(mode_pin),
    .prog_timer_req(prog_timer_req), .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr),
    .cpu_instr_done(cpu_instr_done), .cpu_swi(cpu_swi), .cpu_rti(cpu_rti),
    .cpu_stacked_mask(cpu_stacked_mask), .cpu_mask_set(cpu_mask_set),
    .cpu_mask_clr(cpu_mask_clr), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
    .sys_reset(sys_reset),
    .vector_load(vector_load), .vector_hi_addr(vector_hi_addr),
    .vector_lo_addr(vector_lo_addr), .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_addr(stack_addr), .mask_bit(mask_bit), .wake(wake), .op_mode(op_mode));

  rstirq_cpu_model cpu (.mclk(mclk), .vector_load(vector_load),
    .vector_hi_addr(vector_hi_addr), .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_addr(stack_addr), .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr),
    .cpu_instr_done(cpu_instr_done), .cpu_swi(cpu_swi), .cpu_rti(cpu_rti),
    .cpu_stacked_mask(cpu_stacked_mask), .cpu_mask_set(cpu_mask_set),
    .cpu_mask_clr(cpu_mask_clr));

  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r & m);
    chk("pslverr", 32'h0, e);
  endtask : rd

  task automatic exit_chk();
    int i;
    for (i = 0; i < 40 && vector_load !== 1'b1; i++) @(posedge mclk);
    chk("reset_exit", 32'h1, vector_load);
    chk("sys_reset", 32'h0, sys_reset);
    chk("vec_hi", 32'h0FFE, vector_hi_addr);
    chk("vec_lo", 32'h0FFF, vector_lo_addr);
    chk("mask", 32'h1, mask_bit);
  endtask : exit_chk

  task automatic ent(input logic software_trap_instr, input logic [15:0] ev);
    logic [15:0] v;
    logic [7:0] a;
    int n;
    cpu.boundary(software_trap_instr, v, n, a);
    chk("vector", ev, v);
    chk("pushes", (ev == 16'h0) ? 32'h0 : 32'h5, 32'(n));
    if (ev != 16'h0) chk("push_top", 32'hFF, a);
    if (ev != 16'h0) chk("mask_entry", 32'h1, mask_bit);
  endtask : ent

  task automatic ret(input logic m);
    int n;
    cpu.return_from_trap_instr(m, n);
    chk("pops", 32'h5, 32'(n));
    chk("mask_rti", 32'(m), mask_bit);
  endtask : ret

  task automatic irq_pulse();
    @(posedge mclk);
    irq_pin_n <= 1'b0;
    repeat (3) @(posedge mclk);
    irq_pin_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : irq_pulse

  task automatic t_por();
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("held_by_pin", 32'h1, sys_reset);
    rst_pin_n <= 1'b1;
    exit_chk();
    rd("ctrl_reset", 8'h00, 32'hFFFF, 32'h0F00);
  endtask : t_por

  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, r);
  endtask : t_unmapped

  // Pin and timer both pending; a repeat pulse during service relatches
  task automatic t_irq();
    cpu.mask_op(1'b0);
    prog_timer_req <= 1'b1;
    irq_pulse();
    ent(1'b0, 16'h0FFA);
    irq_pulse();
    ent(1'b0, 16'h0000);
    ret(1'b0);
    ent(1'b0, 16'h0FFA);
    ret(1'b0);
    ent(1'b0, 16'h0FF6);
    prog_timer_req <= 1'b0;
    ret(1'b0);
    ent(1'b0, 16'h0000);
  endtask : t_irq

  task automatic t_swi();
    cpu.mask_op(1'b1);
    ent(1'b1, 16'h0FFC);
    ret(1'b1);
  endtask : t_swi

  task automatic t_core_timer_unit();
    wr(8'h00, 32'h0000_0F0C);
    repeat (300) @(posedge mclk);
    rd("timer_flags", 8'h04, 32'h3, 32'h3);
    cpu.mask_op(1'b0);
    ent(1'b0, 16'h0FF8);
    ret(1'b0);
    wr(8'h00, 32'h0000_0F00);
    wr(8'h04, 32'h0000_0003);
    ent(1'b0, 16'h0000);
  endtask : t_core_timer_unit

  task automatic t_illegal();
    cpu.fetch(16'h017F);
    repeat (4) @(posedge mclk);
    chk("legal_fetch", 32'h0, sys_reset);
    cpu.fetch(16'h0180);
    exit_chk();
    rd("cause_illegal", 8'h04, 32'h40, 32'h40);
  endtask : t_illegal

  task automatic t_wdog();
    int i;
    mode_pin <= 1'b0;
    wr(8'h00, 32'h0000_0F02);
    for (i = 0; i < 3; i++) begin
      repeat (40) @(posedge mclk);
      wr(8'h0C, 32'h0000_0000);
    end
    rd("no_wdog_yet", 8'h04, 32'h80, 32'h0);
    for (i = 0; i < 200 && sys_reset !== 1'b1; i++) @(posedge mclk);
    chk("wdog_reset", 32'h1, sys_reset);
    exit_chk();
    wr(8'h00, 32'h0000_0F00);
    chk("mode_kept", 32'h1, op_mode);
    rd("cause_wdog", 8'h04, 32'h80, 32'h80);
  endtask : t_wdog

  // A one-cycle glitch is below the minimum low time
  task automatic t_pin();
    wr(8'h00, 32'h0000_0F1D);
    @(posedge mclk);
    rst_pin_n <= 1'b0;
    @(posedge mclk);
    rst_pin_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("glitch", 32'h0, sys_reset);
    rst_pin_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("pin_reset", 32'h1, sys_reset);
    rst_pin_n <= 1'b1;
    exit_chk();
    chk("mode_recaptured", 32'h0, op_mode);
    rd("ctrl_cleared", 8'h00, 32'hFFFF, 32'h0F00);
  endtask : t_pin

  // Stop ignores timers; the shared vector is told apart by the keypad flag
  task automatic t_keypad();
    wr(8'h00, 32'h0000_0F04);
    cpu_stop <= 1'b1;
    repeat (40) @(posedge mclk);
    chk("stop_timer_wake", 32'h0, wake);
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("wait_timer_wake", 32'h1, wake);
    cpu_wait <= 1'b0;
    wr(8'h00, 32'h0000_0F10);
    wr(8'h04, 32'h0000_0003);
    cpu_stop <= 1'b1;
    kbd_pins_n <= 6'h3E;
    repeat (6) @(posedge mclk);
    chk("stop_keypad_wake", 32'h1, wake);
    cpu_stop <= 1'b0;
    rd("keypad_flag", 8'h04, 32'h4, 32'h4);
    cpu.mask_op(1'b0);
    ent(1'b0, 16'h0FFA);
    ret(1'b0);
    kbd_pins_n <= 6'h3F;
    wr(8'h04, 32'h0000_0004);
    ent(1'b0, 16'h0000);
  endtask : t_keypad

  initial begin
    t_por();
    t_unmapped();
    t_irq();
    t_swi();
    t_core_timer_unit();
    t_illegal();
    t_wdog();
    t_pin();
    t_keypad();
    end_of_test();
  end
endmodule : tb_top

//--- verilog/rstirq_ctrl.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rstirq_params.svh"

// How it works
// - Any reset restarts at 0FFE, sets mask
// - Power-up delay, then wait for pin high
// - Pin low 1.5 cycles resets; resume after
// - Fetch outside legal regions forces reset
// - Watchdog reset keeps current operating mode
// - Watchdog enable by build option or bit
// - Five sources; pin edge or edge-level
// - Entry stacks registers, then sets mask
// - Return unstacks, mask from stacked codes
// - Service only at boundary, unmasked, enabled
// - Power-on or pin reset clears enables
// - Fixed priority reset, trap, ext, ct, pt
// - Software trap ignores mask, higher than pending
// - Mask set blocks all maskable requests
// - External latch cleared on entry, relatches
// - Tick or wrap share core timer vector
// - Tick flag set after configured count
// - Wrap flag set on FF to 00
// - Vector high byte 0FFE, low 0FFF
// - Stop wakes on ext/keypad; wait also timers
// - Each entry uses five stack locations
module rstirq_ctrl
  import rstirq_pkg::*;
#(
  parameter int POR_CYCLES = `RSTIRQ_POR_DELAY_CYCLES,
  parameter int WDOG_CYCLES = `RSTIRQ_WDOG_CYCLES,
  parameter bit WDOG_PROGRAMMABLE = 1'b1,
  parameter bit WDOG_MASK_EN = 1'b1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rst_pin_n,
  input wire logic irq_pin_n,
  input wire logic [5:0] kbd_pins_n,
  input wire logic mode_pin,
  input wire logic prog_timer_req,
  input wire logic cpu_fetch,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_instr_done,
  input wire logic cpu_swi,
  input wire logic cpu_rti,
  input wire logic cpu_stacked_mask,
  input wire logic cpu_mask_set,
  input wire logic cpu_mask_clr,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  output logic sys_reset,
  output logic vector_load,
  output logic [15:0] vector_hi_addr,
  output logic [15:0] vector_lo_addr,
  output logic stack_push,
  output logic stack_pop,
  output logic [7:0] stack_addr,
  output logic mask_bit,
  output logic wake,
  output logic op_mode
);

  localparam int RST_PIN_MIN = `RSTIRQ_RST_PIN_MIN_CYC;

  function automatic logic legal_fetch(input logic [15:0] a);
    legal_fetch = (a >= `RSTIRQ_RAM_LO && a <= `RSTIRQ_RAM_HI) ||
                  (a >= `RSTIRQ_EE_LO && a <= `RSTIRQ_EE_HI) ||
                  (a >= `RSTIRQ_PROG_LO && a <= `RSTIRQ_PROG_HI) ||
                  (a >= `RSTIRQ_VTAB_LO && a <= `RSTIRQ_VTAB_HI);
  endfunction : legal_fetch

  rstirq_regs_s s;
  rstirq_regs_s next_s;

  logic wdog_en;
  logic wd_fire;
  logic pin_rst;
  logic ill_rst;
  logic irq_low;
  logic ext_req;
  logic kbd_req;
  logic ct_req;
  logic pt_req;

  assign wdog_en = WDOG_PROGRAMMABLE ? s.ctl[`RSTIRQ_CTL_WDOG_OPT] : WDOG_MASK_EN;
  assign wd_fire = wdog_en && (s.wdog_cnt == `RSTIRQ_WDOG_CNT_W'(WDOG_CYCLES - 1));
  // Low sample that completes the minimum width
  assign pin_rst = !s.rpin_s[1] && (s.rpin_cnt >= 2'(RST_PIN_MIN - 1));
  assign ill_rst = cpu_fetch && !legal_fetch(cpu_addr);
  assign irq_low = !s.irq_s[1];
  assign ext_req = s.ext_latch || (s.ctl[`RSTIRQ_CTL_EXT_LEVEL] && irq_low);
  assign kbd_req = s.keypad_status_flag && s.ctl[`RSTIRQ_CTL_KBD_IE];
  assign ct_req = (s.rtf && s.ctl[`RSTIRQ_CTL_RT_IE]) ||
                  (s.ctf && s.ctl[`RSTIRQ_CTL_WRAP_IE]);
  assign pt_req = prog_timer_req;

  always_comb begin
    logic wr;
    logic rd;
    logic [3:0] stat_clr;
    logic [3:0] cause_clr;
    logic [3:0] cause_set;
    logic ext_clr;
    logic rt_hit;
    logic kb_any;
    logic por_hold;
    logic [15:0] v;
    logic take;
    wr = 1'b0;
    rd = 1'b0;
    stat_clr = 4'h0;
    cause_clr = 4'h0;
    cause_set = 4'h0;
    ext_clr = 1'b0;
    rt_hit = 1'b0;
    kb_any = 1'b0;
    por_hold = 1'b0;
    v = `RSTIRQ_VEC_PT;
    take = 1'b0;
    next_s = s;
    // Pin synchronisers; stage 0 only feeds stage 1
    next_s.rpin_s = {s.rpin_s[0], rst_pin_n};
    next_s.irq_s = {s.irq_s[0], irq_pin_n};
    next_s.mode_s = {s.mode_s[0], mode_pin};
    next_s.kb_s1 = kbd_pins_n;
    next_s.kb_s2 = s.kb_s1;
    next_s.vec_load = 1'b0;
    next_s.push = 1'b0;
    next_s.pop = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    if (s.rpin_s[1]) begin
      next_s.rpin_cnt = 2'h0;
    end else if (s.rpin_cnt != 2'h3) begin
      next_s.rpin_cnt = s.rpin_cnt + 2'h1;
    end
    if (!s.por_done) begin
      por_hold = 1'b1;
      if (s.por_cnt == `RSTIRQ_POR_CNT_W'(POR_CYCLES - 1)) begin
        next_s.por_done = 1'b1;
      end else begin
        next_s.por_cnt = s.por_cnt + `RSTIRQ_POR_CNT_W'(1);
      end
    end

    // APB slave: one wait state, answer registered
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (paddr[7:2])
        `RSTIRQ_REG_CTRL: next_s.prdata = {16'h0000, s.ctl};
        `RSTIRQ_REG_STAT: next_s.prdata = {24'h000000, s.cause, s.ext_latch, s.keypad_status_flag, s.ctf, s.rtf};
        `RSTIRQ_REG_COUNT: next_s.prdata = {24'h000000, s.ct_cnt};
        `RSTIRQ_REG_WDOG: next_s.prdata = 32'h0000_0000;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    wr = psel && penable && s.pready && pwrite && !s.pslverr;
    rd = psel && penable && s.pready && !pwrite;
    if (wr) begin
      case (paddr[7:2])
        `RSTIRQ_REG_CTRL: next_s.ctl = pwdata[15:0];
        `RSTIRQ_REG_STAT: begin
          stat_clr = {1'b0, pwdata[2:0]};
          cause_clr = pwdata[7:4];
        end
        default: stat_clr = 4'h0;
      endcase
    end

    // Core timer counter and tick divider
    next_s.ct_cnt = s.ct_cnt + 8'h01;
    if (s.ctl[`RSTIRQ_CTL_RT_IE]) begin
      if (s.rt_cnt >= s.ctl[15:8]) begin
        rt_hit = 1'b1;
        next_s.rt_cnt = 8'h00;
      end else begin
        next_s.rt_cnt = s.rt_cnt + 8'h01;
      end
    end else begin
      next_s.rt_cnt = 8'h00;
    end
    // Set beats a same-cycle software clear
    next_s.rtf = (s.rtf && !stat_clr[`RSTIRQ_ST_RTF]) || rt_hit;
    next_s.ctf = (s.ctf && !stat_clr[`RSTIRQ_ST_CTF]) ||
                 (s.ctl[`RSTIRQ_CTL_WRAP_IE] && s.ct_cnt == 8'hFF);
    kb_any = |(~s.kb_s2);
    next_s.kb_prev = kb_any;
    next_s.keypad_status_flag = (s.keypad_status_flag && !stat_clr[`RSTIRQ_ST_KSF]) || (kb_any && !s.kb_prev);
    next_s.irq_prev = irq_low;

    // Watchdog restart on a zero in bit 0
    // Firing clears the count so one timeout gives one reset cycle
    if (!wdog_en || wd_fire || s.st == ST_RESET ||
        (wr && paddr[7:2] == `RSTIRQ_REG_WDOG && !pwdata[0])) begin
      next_s.wdog_cnt = '0;
    end else if (!wd_fire) begin
      next_s.wdog_cnt = s.wdog_cnt + `RSTIRQ_WDOG_CNT_W'(1);
    end

    if (por_hold || pin_rst || ill_rst || wd_fire) begin
      next_s.st = ST_RESET;
      next_s.sys_reset = 1'b1;
      next_s.fcnt = 3'h0;
      cause_set = {wd_fire, ill_rst, pin_rst, por_hold};
      if (pin_rst || por_hold) begin
        // Watchdog and illegal fetch keep enables and mode
        next_s.ctl = `RSTIRQ_CTL_RESET;
        next_s.op_mode = s.mode_s[1];
        ext_clr = 1'b1;
      end
    end else begin
      case (s.st)
        ST_RESET: begin
          if (s.rpin_s[1]) begin
            next_s.st = ST_RUN;
            next_s.sys_reset = 1'b0;
            next_s.vec_load = 1'b1;
            next_s.vec = `RSTIRQ_VEC_RESET;
            next_s.vec_lo = {`RSTIRQ_VEC_RESET | 16'h0001};
            next_s.mask = 1'b1;
            next_s.sp = `RSTIRQ_SP_RESET;
          end
        end
        ST_RUN: begin
          if (cpu_mask_set) begin
            next_s.mask = 1'b1;
          end else if (cpu_mask_clr) begin
            next_s.mask = 1'b0;
          end
          if (cpu_rti) begin
            next_s.st = ST_UNSTACK;
            next_s.fcnt = `RSTIRQ_STACK_FRAME;
          end else if (cpu_instr_done) begin
            // Software trap is taken ahead of any pending source, masked or not
            if (cpu_swi) begin
              take = 1'b1;
              v = `RSTIRQ_VEC_SWI;
            end else if (!s.mask) begin
              take = ext_req || kbd_req || ct_req || pt_req;
              if (ext_req || kbd_req) begin
                v = `RSTIRQ_VEC_EXT;
                ext_clr = ext_req;
              end else if (ct_req) begin
                v = `RSTIRQ_VEC_CT;
              end else begin
                v = `RSTIRQ_VEC_PT;
              end
            end
          end
          if (take) begin
            next_s.st = ST_STACK;
            next_s.fcnt = `RSTIRQ_STACK_FRAME;
            next_s.vec = v;
            next_s.vec_lo = v | 16'h0001;
          end
        end
        ST_STACK: begin
          if (s.fcnt != 3'h0) begin
            next_s.push = 1'b1;
            next_s.stk_addr = {2'b11, s.sp};
            next_s.sp = s.sp - 6'h01;
            next_s.fcnt = s.fcnt - 3'h1;
          end else begin
            next_s.mask = 1'b1;
            next_s.vec_load = 1'b1;
            next_s.st = ST_RUN;
          end
        end
        ST_UNSTACK: begin
          if (s.fcnt != 3'h0) begin
            next_s.pop = 1'b1;
            next_s.stk_addr = {2'b11, 6'(s.sp + 6'h01)};
            next_s.sp = s.sp + 6'h01;
            next_s.fcnt = s.fcnt - 3'h1;
          end else begin
            next_s.mask = cpu_stacked_mask;
            next_s.st = ST_RUN;
          end
        end
        default: next_s.st = ST_RESET;
      endcase
    end
    next_s.cause = (s.cause & ~cause_clr) | cause_set;
    next_s.ext_latch = (s.ext_latch && !ext_clr) || (irq_low && !s.irq_prev);
    // Wake ignores the mask, as the core re-checks it on resuming
    next_s.wake = (cpu_stop && (ext_req || kbd_req)) ||
                  (cpu_wait && (ext_req || kbd_req || ct_req || pt_req));
    if (rd) begin
      next_s.prdata = s.prdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= ST_RESET;
      s.rpin_s <= 2'b11;
      s.irq_s <= 2'b11;
      s.kb_s1 <= 6'h3F;
      s.kb_s2 <= 6'h3F;
      s.ctl <= `RSTIRQ_CTL_RESET;
      s.cause <= 4'h1;
      s.mask <= 1'b1;
      s.sp <= `RSTIRQ_SP_RESET;
      s.sys_reset <= 1'b1;
      s.vec <= `RSTIRQ_VEC_RESET;
      s.vec_lo <= 16'h0FFF;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign sys_reset = s.sys_reset;
  assign vector_load = s.vec_load;
  assign vector_hi_addr = s.vec;
  assign vector_lo_addr = s.vec_lo;
  assign stack_push = s.push;
  assign stack_pop = s.pop;
  assign stack_addr = s.stk_addr;
  assign mask_bit = s.mask;
  assign wake = s.wake;
  assign op_mode = s.op_mode;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  a_reset_vector_fetch: assert property ($fell(s.sys_reset) |->
    s.vec_load && s.vec == `RSTIRQ_VEC_RESET && s.vec_lo == 16'h0FFF && s.mask)
    else $error("reset exit without reset vector and mask");
  a_pin_low_reset: assert property (!s.rpin_s[1] && s.por_done ##1 !s.rpin_s[1] |=>
    s.sys_reset)
    else $error("pin held low did not reset");
  a_illegal_fetch_reset: assert property (ill_rst |=> s.sys_reset && s.cause[2])
    else $error("illegal fetch did not reset");
  a_wdog_timeout_reset: assert property (wd_fire && s.por_done |=>
    s.sys_reset && s.cause[3] && s.op_mode == $past(s.op_mode))
    else $error("watchdog timeout reset wrong");
  a_stack_five_push: assert property ($rose(s.push) |-> s.push[*5] ##1 !s.push)
    else $error("entry did not push five locations");
  a_mask_after_stack: assert property ($fell(s.push) |-> s.mask && s.vec_load)
    else $error("mask not set after stacking");
  a_rti_mask_restore: assert property ($fell(s.pop) |-> s.mask == $past(cpu_stacked_mask))
    else $error("return did not restore mask");
  a_mask_blocks_hw: assert property (s.st == ST_RUN && s.mask && cpu_instr_done &&
    !cpu_swi && !cpu_rti && !pin_rst && !ill_rst && !wd_fire && !cpu_mask_clr |=>
    s.st == ST_RUN)
    else $error("masked interrupt was taken");
  a_swi_ignores_mask: assert property (s.st == ST_RUN && cpu_instr_done && cpu_swi &&
    !cpu_rti && !pin_rst && !ill_rst && !wd_fire |=>
    s.st == ST_STACK && s.vec == `RSTIRQ_VEC_SWI)
    else $error("software trap not taken");
  a_ext_priority: assert property (s.st == ST_RUN && cpu_instr_done && !cpu_swi && !cpu_rti &&
    !s.mask && ext_req && !pin_rst && !ill_rst && !wd_fire |=>
    s.vec == `RSTIRQ_VEC_EXT ##1 !s.ext_latch || irq_low)
    else $error("external request not first or latch kept");
  a_wrap_flag: assert property (s.ct_cnt == 8'hFF && s.ctl[`RSTIRQ_CTL_WRAP_IE] |=> s.ctf)
    else $error("counter wrap did not set flag");
  a_enables_cleared: assert property (pin_rst |=> s.ctl[4:2] == 3'b000)
    else $error("pin reset left enables set");

  c_swi_entry: cover property (s.st == ST_STACK && s.vec == `RSTIRQ_VEC_SWI);
  c_ext_entry: cover property ($fell(s.push) && s.vec == `RSTIRQ_VEC_EXT);
  c_rti_done: cover property ($fell(s.pop));
  c_pin_reset: cover property (pin_rst ##[1:20] $fell(s.sys_reset));

endmodule : rstirq_ctrl
